/* dv/asp_drive_model.sv */
// Drive model: decodes steps from the two outputs and checks pulse timing.
// Assumes the bench sets the format and the programmed counts in cycles.
`timescale 1ns/1ps

module asp_drive_model (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Observed outputs and setup
    input  wire asp_pkg::asp_drive_s drive,
    input  wire logic          [1:0] fmt,
    input  wire logic          [7:0] len_c,
    input  wire logic          [7:0] gap_c,
    input  wire logic          [7:0] dd_c,
    // Results
    output logic signed       [31:0] steps,
    output logic              [15:0] viol
);
    import asp_pkg::*;
    logic [1:0] p;
    logic [1:0] q;
    logic [1:0] fmt_q;
    logic [7:0] hi_n;
    logic [7:0] lo_n;
    logic [7:0] dir_n;
    assign p = {drive.out1, drive.out2};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= 2'b00;
            fmt_q <= 2'b11;
            steps <= '0;
            viol <= '0;
            hi_n <= '0;
            lo_n <= 8'hff;
            dir_n <= 8'hff;
        end else begin
            q <= p;
            fmt_q <= fmt;
            hi_n <= p[1] ? hi_n + 8'h01 : 8'h00;
            lo_n <= p[1] ? 8'h00 : ((lo_n == 8'hff) ? lo_n : lo_n + 8'h01);
            dir_n <= (p[0] != q[0]) ? 8'h00 : ((dir_n == 8'hff) ? dir_n : dir_n + 8'h01);
            // Format 3 only tracks, so polarity games never count as steps
            if (fmt != fmt_q) begin
                steps <= '0;
            end else if (fmt == 2'b00) begin
                if (p[1] && !q[1]) steps <= p[0] ? steps - 1 : steps + 1;
                if (!p[1] && q[1] && hi_n != len_c) viol <= viol + 16'h1;
                if (p[1] && !q[1] && (lo_n < gap_c || dir_n + 1 < dd_c)) viol <= viol + 16'h1;
                if (p[0] != q[0] && (q[1] || lo_n + 1 < dd_c)) viol <= viol + 16'h1;
            end else if (fmt == 2'b01) begin
                steps <= steps + {31'b0, p[1] & ~q[1]} - {31'b0, p[0] & ~q[0]};
            end else if (fmt == 2'b10 && p != q) begin
                if (p == {q[0], ~q[1]}) steps <= steps + 1;
                else if (p == {~q[0], q[1]}) steps <= steps - 1;
                else viol <= viol + 16'h1;
            end
        end
    end
endmodule : asp_drive_model

/* dv/axis_step_pulse_generator_tb_top.sv */
// Bench of the step pulse generator: register stimulus, drive model checks.
// Assumes asp_pkg compiled first and asp_defs.svh on the include path.
`timescale 1ns/1ps
`include "asp_defs.svh"

module axis_step_pulse_generator_tb_top;
    import asp_pkg::*;
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    asp_bus_s           req = '0;
    logic        [31:0] rdata;
    asp_drive_s         drive;
    logic         [1:0] fmt = 2'b11;
    logic signed [31:0] steps;
    logic        [15:0] viol;
    logic        [31:0] v;
    logic        [31:0] w;
    logic signed [31:0] c0;
    logic        [15:0] scale;
    int                 failures = 0;
    int                 cmp_count = 0;
    int                 seed = 84144;
    always #2 clk = ~clk;
    asp_stepgen DUT (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .drive(drive));
    asp_drive_model PM (.clk(clk), .reset_n(reset_n), .drive(drive), .fmt(fmt), .len_c(8'h02),
        .gap_c(8'h02), .dd_c(8'h0a), .steps(steps), .viol(viol));
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] exp_fb(logic signed [31:0] n, logic [15:0] s);
        longint r;
        r = (longint'(n) * 65536) / longint'(s);
        return r[31:0];
    endfunction : exp_fb
    function automatic logic [31:0] exp_max(int cyc, int vel, logic [15:0] s);
        return 32'(longint'(cyc) * vel * s / 250000000 + 1);
    endfunction : exp_max
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // Generous span: the main sequence needs about 35k of the 100k cycles
    initial begin
        #400000;
        failures++;
        end_sim();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`ASP_OFS_CTRL, v);
        chk("ctrl", `ASP_CTRL_RST, v);
        rd(`ASP_OFS_SCALE, v);
        chk("scale", 32'h1, v);
        wr(`ASP_OFS_COUNT, 32'h5);
        rd(`ASP_OFS_COUNT, v);
        chk("count", 32'h0, v);
        rd(8'h30, v);
        chk("unmapped", 32'h0, v);
        for (int p = 3; p >= 0; p--) begin
            wr(`ASP_OFS_CTRL, 32'(p << 4));
            repeat (2) @(posedge clk);
            #1 chk("polarity", {30'b0, 2'(p) == 2'd1 || p == 3, p > 1}, {30'b0, drive});
        end
        scale = 16'(500 + $unsigned($random(seed)) % 500);
        wr(`ASP_OFS_SCALE, {16'h0, scale});
        wr(`ASP_OFS_STEPLEN, 32'd8);
        wr(`ASP_OFS_STEPSPACE, 32'd8);
        wr(`ASP_OFS_DIRDELAY, 32'd40);
        for (int f = 0; f < 3; f++) begin
            wr(`ASP_OFS_CTRL, 32'(f << 2));
            repeat (4) @(posedge clk);
            fmt <= 2'(f);
            rd(`ASP_OFS_COUNT, v);
            c0 = v;
            wr(`ASP_OFS_VEL_CMD, (32'd3000 + $unsigned($random(seed)) % 2000) << 16);
            wr(`ASP_OFS_CTRL, 32'(f << 2) | 32'h3);
            repeat (3000) @(posedge clk);
            wr(`ASP_OFS_VEL_CMD, -((32'd1000 + $unsigned($random(seed)) % 1000) << 16));
            repeat (3000) @(posedge clk);
            wr(`ASP_OFS_VEL_CMD, 32'h0);
            repeat (100) @(posedge clk);
            wr(`ASP_OFS_CTRL, 32'(f << 2));
            rd(`ASP_OFS_COUNT, v);
            chk("steps", v - c0, steps);
            chk("net_dir", 32'h1, 32'($signed(v - c0) > 0));
            // Fast enough to give several steps if enable were ignored
            wr(`ASP_OFS_VEL_CMD, 32'd4000 << 16);
            repeat (500) @(posedge clk);
            chk("disabled", v - c0, steps);
            rd(`ASP_OFS_COUNT, w);
            chk("disabled_count", v, w);
        end
        fmt <= 2'b11;
        chk("timing", 32'h0, {16'h0, viol});
        wr(`ASP_OFS_MAXVEL, 32'd1000 << 16);
        rd(`ASP_OFS_COUNT, v);
        c0 = v;
        wr(`ASP_OFS_VEL_CMD, 32'd5000 << 16);
        wr(`ASP_OFS_CTRL, 32'h3);
        repeat (5000) @(posedge clk);
        wr(`ASP_OFS_CTRL, 32'h0);
        rd(`ASP_OFS_COUNT, v);
        w = exp_max(5000, 1000, scale);
        chk("vel_limit", 32'h1, 32'($signed(v - c0) <= $signed(w) && $signed(v - c0) > 0));
        wr(`ASP_OFS_MAXVEL, 32'h0);
        // Ramp of scale steps/s per second: far below one step in this span
        wr(`ASP_OFS_MAXACC, 32'h00010000);
        wr(`ASP_OFS_CTRL, 32'h3);
        repeat (2000) @(posedge clk);
        wr(`ASP_OFS_CTRL, 32'h0);
        wr(`ASP_OFS_MAXACC, 32'h0);
        rd(`ASP_OFS_COUNT, w);
        chk("accel_limit", v, w);
        wr(`ASP_OFS_POS_CMD, 32'hfff80000);
        c0 = v;
        wr(`ASP_OFS_CTRL, 32'h1);
        repeat (8000) @(posedge clk);
        wr(`ASP_OFS_CTRL, 32'h0);
        repeat (200) @(posedge clk);
        rd(`ASP_OFS_COUNT, v);
        chk("pos_loop", 32'h1, 32'($signed(v - c0) < 0));
        rd(`ASP_OFS_POSFB, w);
        chk("posfb", exp_fb(v, scale), w);
        end_sim();
    end
endmodule : axis_step_pulse_generator_tb_top

/* include/asp_defs.svh */
// Constants of the axis step pulse generator: offsets, resets, timing.
// Included by the package; holds definitions only.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ASP_CLK_PERIOD_NS 4
`define ASP_CLK_HZ        32'h0ee6b280
`define ASP_FRAC          16
`define ASP_POS_GAIN      32'sh000003e8
`define ASP_ERR_LIM       32'sh00010000
`define ASP_DIV_LAST      6'h2f

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASP_OFS_CTRL      8'h00
`define ASP_OFS_POS_CMD   8'h04
`define ASP_OFS_VEL_CMD   8'h08
`define ASP_OFS_MAXVEL    8'h0c
`define ASP_OFS_MAXACC    8'h10
`define ASP_OFS_SCALE     8'h14
`define ASP_OFS_STEPLEN   8'h18
`define ASP_OFS_STEPSPACE 8'h1c
`define ASP_OFS_DIRDELAY  8'h20
`define ASP_OFS_COUNT     8'h24
`define ASP_OFS_POSFB     8'h28
`define ASP_OFS_STATUS    8'h2c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASP_CTRL_RST      32'h00000000
`define ASP_SCALE_RST     16'h0001

`endif

/* include/asp_pkg.sv */
// Types of the axis step pulse generator.
// Assumes asp_defs.svh on the include path.
`include "asp_defs.svh"

package asp_pkg;

    typedef enum logic [1:0] {
        ASP_STEP_DIR = 2'b00,
        ASP_UP_DOWN  = 2'b01,
        ASP_QUAD     = 2'b10
    } asp_fmt_e;

    typedef enum logic [1:0] {
        ASP_IDLE  = 2'b00,
        ASP_SETUP = 2'b01,
        ASP_PULSE = 2'b10,
        ASP_SPACE = 2'b11
    } asp_state_e;

    typedef struct packed {
        logic [25:0] rsv;
        logic        channel_two_polarity;
        logic        channel_one_polarity;
        asp_fmt_e    fmt;
        logic        vel_mode;
        logic        enable;
    } asp_ctrl_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } asp_bus_s;

    typedef struct packed {
        logic out1;
        logic out2;
    } asp_drive_s;

endpackage : asp_pkg

/* logic/asp_div.sv */
// Sequential divider: signed step count to Q16.16 position units.
// Assumes a steady clock; restarts by itself whenever idle.
`timescale 1ns/1ps

module asp_div (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Operands
    input  wire logic signed [31:0] count,
    input  wire logic        [15:0] divisor,
    // Result
    output logic signed      [31:0] quotient
);
    import asp_pkg::*;

    logic        [47:0] num_q;
    logic        [16:0] rem_q;
    logic        [5:0]  bit_q;
    logic               busy_q;
    logic               neg_q;

    wire         [31:0] mag   = count[31] ? 32'(-count) : count;
    wire         [16:0] trial = {rem_q[15:0], num_q[47]};
    wire                fits  = trial >= {1'b0, divisor};
    wire         [31:0] res   = {num_q[30:0], fits};

    // One quotient bit a cycle: small area, feedback lags by 48 cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            num_q    <= '0;
            rem_q    <= '0;
            bit_q    <= '0;
            busy_q   <= 1'b0;
            neg_q    <= 1'b0;
            quotient <= '0;
        end else if (!busy_q) begin
            num_q  <= {mag, 16'h0000};
            rem_q  <= '0;
            bit_q  <= `ASP_DIV_LAST;
            busy_q <= 1'b1;
            neg_q  <= count[31];
        end else begin
            rem_q <= fits ? 17'(trial - {1'b0, divisor}) : trial;
            num_q <= {num_q[46:0], fits};
            bit_q <= bit_q - 6'h01;
            if (bit_q == 6'h00) begin
                busy_q   <= 1'b0;
                quotient <= neg_q ? 32'(-res) : res;
            end
        end
    end

endmodule : asp_div

/* logic/asp_stepgen.sv */
// Axis step pulse generator: register port, velocity shaping, pulse timing.
// Assumes a 250 MHz clk and a host that writes parameters periodically.
//
// Behaviour
// - Format 0 step plus direction, 1 up and down, 2 quadrature.
// - No step pulses on either output while enable is low.
// - Velocity mode follows commanded velocity, position mode commanded position.
// - Channel one polarity bit inverts output one, the step pulse.
// - Channel two polarity bit inverts output two, the direction level.
// - Speed limited to maximum velocity; zero turns the limit off.
// - Velocity change limited to maximum acceleration; zero turns it off.
// - Each step pulse lasts the programmed width in nanoseconds, rounded up to whole 4 ns clocks, at least one.
// - Programmed idle time kept between pulse end and next pulse.
// - Programmed interval kept between a pulse and any direction change.
// - Steps per unit scale converts position units into steps.
// - Step count reported as signed 32-bit count of issued steps.
// - Position reported in units, step count divided by the scale.
// - Commanded position used only in position mode.
// - Commanded velocity used only in velocity mode.
// - Pulses run on their own between periodic host writes.
`timescale 1ns/1ps

module asp_stepgen (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire asp_pkg::asp_bus_s req,
    output logic            [31:0] rdata,
    // Drive outputs
    output asp_pkg::asp_drive_s    drive
);
    import asp_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic signed [31:0] to_steps(
        input logic signed [31:0] u,
        input logic        [15:0] s);
        logic signed [48:0] p;
        p = u * $signed({1'b0, s});
        to_steps = p[`ASP_FRAC+31:`ASP_FRAC];
    endfunction : to_steps

    function automatic logic [15:0] ns_to_cyc(input logic [15:0] ns);
        logic [16:0] c;
        c = ({1'b0, ns} + 17'(`ASP_CLK_PERIOD_NS - 1)) / 17'(`ASP_CLK_PERIOD_NS);
        ns_to_cyc = (c == 17'h00000) ? 16'h0001 : c[15:0];
    endfunction : ns_to_cyc

    function automatic logic [32:0] dds_sum(
        input logic [31:0] acc,
        input logic [31:0] inc);
        dds_sum = {1'b0, acc} + {1'b0, inc};
    endfunction : dds_sum

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    asp_ctrl_s          ctrl_q;
    logic signed [31:0] pos_cmd_q;
    logic signed [31:0] vel_cmd_q;
    logic        [31:0] maxvel_q;
    logic        [31:0] maxacc_q;
    logic        [15:0] scale_q;
    logic        [15:0] steplen_q;
    logic        [15:0] space_q;
    logic        [15:0] dirdly_q;
    logic signed [31:0] count_q;
    logic signed [31:0] posfb;
    asp_state_e         st_q;
    asp_state_e         st_d;
    logic               dir_q;

    wire wr_ctrl  = req.wr && req.addr == `ASP_OFS_CTRL;
    wire wr_pos   = req.wr && req.addr == `ASP_OFS_POS_CMD;
    wire wr_vel   = req.wr && req.addr == `ASP_OFS_VEL_CMD;
    wire wr_mxv   = req.wr && req.addr == `ASP_OFS_MAXVEL;
    wire wr_mxa   = req.wr && req.addr == `ASP_OFS_MAXACC;
    wire wr_scale = req.wr && req.addr == `ASP_OFS_SCALE;
    wire wr_len   = req.wr && req.addr == `ASP_OFS_STEPLEN;
    wire wr_spc   = req.wr && req.addr == `ASP_OFS_STEPSPACE;
    wire wr_dly   = req.wr && req.addr == `ASP_OFS_DIRDELAY;

    wire asp_ctrl_s ctrl_wr = {26'h0000000, req.wdata[5:0]};

    // Commands are only stored; they take effect on the next cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= `ASP_CTRL_RST;
            pos_cmd_q <= '0;
            vel_cmd_q <= '0;
            maxvel_q  <= '0;
            maxacc_q  <= '0;
            scale_q   <= `ASP_SCALE_RST;
            steplen_q <= '0;
            space_q   <= '0;
            dirdly_q  <= '0;
        end else begin
            if (wr_ctrl)  ctrl_q    <= ctrl_wr;
            if (wr_pos)   pos_cmd_q <= req.wdata;
            if (wr_vel)   vel_cmd_q <= req.wdata;
            if (wr_mxv)   maxvel_q  <= req.wdata;
            if (wr_mxa)   maxacc_q  <= req.wdata;
            if (wr_scale) scale_q   <= req.wdata[15:0];
            if (wr_len)   steplen_q <= req.wdata[15:0];
            if (wr_spc)   space_q   <= req.wdata[15:0];
            if (wr_dly)   dirdly_q  <= req.wdata[15:0];
        end
    end

    wire [31:0] rd_mux =
        (req.addr == `ASP_OFS_CTRL)      ? ctrl_q           :
        (req.addr == `ASP_OFS_POS_CMD)   ? pos_cmd_q        :
        (req.addr == `ASP_OFS_VEL_CMD)   ? vel_cmd_q        :
        (req.addr == `ASP_OFS_MAXVEL)    ? maxvel_q         :
        (req.addr == `ASP_OFS_MAXACC)    ? maxacc_q         :
        (req.addr == `ASP_OFS_SCALE)     ? {16'h0000, scale_q}   :
        (req.addr == `ASP_OFS_STEPLEN)   ? {16'h0000, steplen_q} :
        (req.addr == `ASP_OFS_STEPSPACE) ? {16'h0000, space_q}   :
        (req.addr == `ASP_OFS_DIRDELAY)  ? {16'h0000, dirdly_q}  :
        (req.addr == `ASP_OFS_COUNT)     ? count_q          :
        (req.addr == `ASP_OFS_POSFB)     ? posfb            :
        (req.addr == `ASP_OFS_STATUS)    ? {29'h00000000, dir_q, st_q} :
        32'h00000000;

    // Read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rdata <= '0;
        else          rdata <= req.rd ? rd_mux : 32'h00000000;
    end

    // ----------------------------------------------------------------
    // Velocity shaping
    // ----------------------------------------------------------------
    wire                en      = ctrl_q.enable;
    wire signed  [31:0] tgt     = to_steps(pos_cmd_q, scale_q);
    wire signed  [31:0] err     = tgt - count_q;
    wire signed  [31:0] err_c   = (err > `ASP_ERR_LIM)  ? `ASP_ERR_LIM :
                                  (err < -`ASP_ERR_LIM) ? -`ASP_ERR_LIM : err;
    wire signed  [31:0] v_pos   = 32'(err_c * `ASP_POS_GAIN);
    wire signed  [31:0] v_vel   = to_steps(vel_cmd_q, scale_q);
    // Only the selected command reaches the loop
    wire signed  [31:0] v_ref   = ctrl_q.vel_mode ? v_vel : v_pos;
    wire signed  [31:0] vmax    = to_steps(maxvel_q, scale_q);
    wire                vlim_on = maxvel_q != 32'h00000000;
    wire signed  [31:0] v_lim   = !vlim_on     ? v_ref :
                                  (v_ref > vmax)  ? vmax  :
                                  (v_ref < -vmax) ? -vmax : v_ref;
    wire         [31:0] amax    = to_steps(maxacc_q, scale_q);
    wire                alim_on = maxacc_q != 32'h00000000;

    logic signed [31:0] v_q;
    logic        [31:0] aph_q;
    logic        [31:0] ph_q;

    // Acceleration as a rate: one step/s of speed per accumulator wrap
    wire         [32:0] a_sum   = dds_sum(aph_q, amax);
    wire                a_tick  = a_sum >= {1'b0, `ASP_CLK_HZ};
    wire         [31:0] aph_d   = a_tick ? 32'(a_sum - {1'b0, `ASP_CLK_HZ}) : a_sum[31:0];
    wire signed  [31:0] v_step  = (v_lim > v_q) ? v_q + 32'sh00000001 :
                                  (v_lim < v_q) ? v_q - 32'sh00000001 : v_q;
    wire signed  [31:0] v_d     = !en      ? 32'sh00000000 :
                                  !alim_on ? v_lim          :
                                  a_tick   ? v_step : v_q;

    // Step rate from a phase accumulator: exact mean rate while the pulse timing keeps up with the wraps
    wire         [31:0] v_abs   = v_q[31] ? 32'(-v_q) : v_q;
    wire         [32:0] ph_sum  = dds_sum(ph_q, v_abs);
    wire                ph_wrap = ph_sum >= {1'b0, `ASP_CLK_HZ};
    wire         [31:0] ph_d    = ph_wrap ? 32'(ph_sum - {1'b0, `ASP_CLK_HZ}) : ph_sum[31:0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            v_q   <= '0;
            aph_q <= '0;
            ph_q  <= '0;
        end else begin
            v_q   <= v_d;
            aph_q <= en ? aph_d : 32'h00000000;
            ph_q  <= en ? ph_d  : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Pulse sequencer
    // ----------------------------------------------------------------
    logic        [15:0] tmr_q;
    logic        [15:0] tmr_d;
    logic        [15:0] quiet_q;
    logic               pend_q;
    logic               pend_dir_q;

    wire [15:0] len_cyc  = ns_to_cyc(steplen_q);
    wire [15:0] spc_cyc  = ns_to_cyc(space_q);
    wire [15:0] dly_cyc  = ns_to_cyc(dirdly_q);
    wire        tmr_done = tmr_q == 16'h0000;
    wire        pulse    = st_q == ASP_PULSE;
    wire        dir_diff = pend_dir_q != dir_q;
    wire        dir_ok   = quiet_q >= dly_cyc;
    wire        go_pulse = en && ((st_q == ASP_IDLE && pend_q && !dir_diff)
                                  || (st_q == ASP_SETUP && tmr_done));
    wire        flip_dir = en && st_q == ASP_IDLE && pend_q && dir_diff && dir_ok;

    always_comb begin
        st_d  = st_q;
        tmr_d = tmr_done ? tmr_q : tmr_q - 16'h0001;
        unique case (st_q)
            ASP_IDLE: begin
                if (flip_dir) begin
                    st_d  = ASP_SETUP;
                    tmr_d = dly_cyc - 16'h0001;
                end else if (go_pulse) begin
                    st_d  = ASP_PULSE;
                    tmr_d = len_cyc - 16'h0001;
                end
            end
            ASP_SETUP: begin
                if (go_pulse) begin
                    st_d  = ASP_PULSE;
                    tmr_d = len_cyc - 16'h0001;
                end
            end
            ASP_PULSE: begin
                if (tmr_done) begin
                    st_d  = ASP_SPACE;
                    tmr_d = spc_cyc - 16'h0001;
                end
            end
            ASP_SPACE: begin
                if (tmr_done) st_d = ASP_IDLE;
            end
        endcase
        if (!en) begin
            st_d  = ASP_IDLE;
            tmr_d = 16'h0000;
        end
    end

    // A wrap arriving while a step is queued is dropped: rate set by timing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q       <= ASP_IDLE;
            tmr_q      <= '0;
            quiet_q    <= '1;
            pend_q     <= 1'b0;
            pend_dir_q <= 1'b0;
            dir_q      <= 1'b0;
        end else begin
            st_q       <= st_d;
            tmr_q      <= tmr_d;
            quiet_q    <= pulse ? 16'h0000 :
                          (&quiet_q) ? quiet_q : quiet_q + 16'h0001;
            pend_q     <= en && (ph_wrap || (pend_q && !go_pulse));
            pend_dir_q <= ph_wrap ? v_q[31] : pend_dir_q;
            dir_q      <= flip_dir ? ~dir_q : dir_q;
        end
    end

    // ----------------------------------------------------------------
    // Position feedback
    // ----------------------------------------------------------------
    logic [1:0] quad_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            quad_q  <= '0;
        end else if (go_pulse) begin
            count_q <= dir_q ? count_q - 32'sh00000001 : count_q + 32'sh00000001;
            quad_q  <= dir_q ? quad_q - 2'h1 : quad_q + 2'h1;
        end
    end

    asp_div u_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .count    (count_q),
        .divisor  (scale_q),
        .quotient (posfb)
    );

    // ----------------------------------------------------------------
    // Output shaping
    // ----------------------------------------------------------------
    wire [1:0] gray = {quad_q[1], quad_q[1] ^ quad_q[0]};
    wire       raw1 = (ctrl_q.fmt == ASP_STEP_DIR) ? pulse :
                      (ctrl_q.fmt == ASP_UP_DOWN)  ? pulse && !dir_q :
                      (ctrl_q.fmt == ASP_QUAD)     ? gray[1] : 1'b0;
    wire       raw2 = (ctrl_q.fmt == ASP_STEP_DIR) ? dir_q :
                      (ctrl_q.fmt == ASP_UP_DOWN)  ? pulse && dir_q :
                      (ctrl_q.fmt == ASP_QUAD)     ? gray[0] : 1'b0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive <= '0;
        end else begin
            drive.out1 <= raw1 ^ ctrl_q.channel_one_polarity;
            drive.out2 <= raw2 ^ ctrl_q.channel_two_polarity;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic [15:0] hi_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) hi_q <= '0;
        else          hi_q <= pulse ? hi_q + 16'h0001 : 16'h0000;
    end
    property p_off;
        !en |=> st_q == ASP_IDLE && !pend_q;
    endproperty
    a_off: assert property (p_off) else $error("pulse logic active while disabled");
    property p_len;
        (pulse && tmr_done && en && $stable(steplen_q)) |-> hi_q == len_cyc - 16'h0001;
    endproperty
    a_len: assert property (p_len) else $error("step pulse width wrong");
    property p_space;
        go_pulse && $stable(space_q) |-> quiet_q >= spc_cyc;
    endproperty
    a_space: assert property (p_space) else $error("idle time between pulses too short");
    property p_dir_gap;
        $changed(dir_q) |-> $past(quiet_q) >= $past(dly_cyc) && $past(st_q) == ASP_IDLE;
    endproperty
    a_dir_gap: assert property (p_dir_gap) else $error("direction changed too near a pulse");
    property p_pol1;
        ctrl_q.fmt == ASP_STEP_DIR && $stable(ctrl_q)
            |=> drive.out1 == ($past(pulse) ^ $past(ctrl_q.channel_one_polarity));
    endproperty
    a_pol1: assert property (p_pol1) else $error("step output polarity wrong");
    property p_pol2;
        ctrl_q.fmt == ASP_STEP_DIR && $stable(ctrl_q)
            |=> drive.out2 == ($past(dir_q) ^ $past(ctrl_q.channel_two_polarity));
    endproperty
    a_pol2: assert property (p_pol2) else $error("direction output polarity wrong");
    // Polarity taken from the pulse cycle: a control write may land on the next edge
    property p_updown;
        ctrl_q.fmt == ASP_UP_DOWN && $stable(ctrl_q) && pulse && !dir_q
            |=> drive.out1 != $past(ctrl_q.channel_one_polarity)
                && drive.out2 == $past(ctrl_q.channel_two_polarity);
    endproperty
    a_updown: assert property (p_updown) else $error("forward pulse on wrong channel");
    property p_count;
        go_pulse && !dir_q |=> count_q == $past(count_q) + 32'sh00000001;
    endproperty
    a_count: assert property (p_count) else $error("step count not advanced");
    property p_quad;
        go_pulse |=> $countones(gray ^ $past(gray)) == 1;
    endproperty
    a_quad: assert property (p_quad) else $error("quadrature moved more than one state");
    property p_vlim;
        $past(en) && en && !alim_on && $stable(maxacc_q) && vlim_on
            && $stable(maxvel_q) && $stable(scale_q) |-> v_q <= vmax && v_q >= -vmax;
    endproperty
    a_vlim: assert property (p_vlim) else $error("velocity above limit");
    property p_accel;
        en && alim_on ##1 en |-> (v_q - $past(v_q)) <= 32'sh00000001
                                  && (v_q - $past(v_q)) >= -32'sh00000001;
    endproperty
    a_accel: assert property (p_accel) else $error("acceleration above limit");
    c_quad_step: cover property (ctrl_q.fmt == ASP_QUAD && go_pulse);
    c_down_pulse: cover property (ctrl_q.fmt == ASP_UP_DOWN && pulse && dir_q);
    c_dir_flip: cover property (flip_dir ##[1:40] go_pulse);

endmodule : asp_stepgen
